// file: src/hcia_top.sv
// Header capture, indirect access window and identification bytes on AHB-Lite
// Contract
// - Header channel in bits 7:6, data type in bits 5:0, read-only.
// - Payload count low byte and high byte at consecutive addresses.
// - Header check byte in bits 5:0 of check register; bit 6 reserved.
// - Bit 7 of check register flags a line length change in a frame.
// - Target select bits 4:2 route accesses: 000 pattern, 001 analog.
// - Auto-step adds one to offset after each indirect data access.
// - Prefetch issues a read strobe whenever the offset is written.
// - Prefetch plus auto-step also strobes a read after each data read.
// - Eight-bit read-write offset picks the register inside the set.
// - Writing the data register writes that byte at current offset.
// - Reading the data register returns the set content at offset.
// - Read-only identification bytes at consecutive addresses.
`timescale 1ns/1ps
`include "hcia_defs.svh"

module hcia_top #(
    parameter hcia_pkg::hcia_byte_t ID_BYTE0 = 8'h61, // Arbitrary value
    parameter hcia_pkg::hcia_byte_t ID_BYTE1 = 8'h62, // Arbitrary value
    parameter hcia_pkg::hcia_byte_t ID_BYTE2 = 8'h63, // Arbitrary value
    parameter hcia_pkg::hcia_byte_t ID_BYTE3 = 8'h64, // Arbitrary value
    parameter hcia_pkg::hcia_byte_t ID_BYTE4 = 8'h65  // Arbitrary value
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    output logic irq,
    input wire logic hdr_valid,
    input wire logic [1:0] hdr_channel,
    input wire logic [5:0] hdr_type,
    input wire logic [15:0] hdr_count,
    input wire logic [5:0] hdr_check,
    input wire logic line_change_event,
    input wire logic frame_start,
    input wire hcia_pkg::hcia_byte_t pattern_rdata,
    input wire hcia_pkg::hcia_byte_t analog_rdata,
    output logic pattern_wr_strobe,
    output logic pattern_rd_strobe,
    output logic analog_wr_strobe,
    output logic analog_rd_strobe,
    output hcia_pkg::hcia_byte_t ind_rd_offset,
    output hcia_pkg::hcia_byte_t ind_wr_offset,
    output hcia_pkg::hcia_byte_t ind_wdata
);
    import hcia_pkg::*;
    hcia_bus_t bus_state;
    hcia_byte_t a_idx, indirect_control, indirect_offset, next_offset, sel_rdata;
    hcia_byte_t header_channel_and_type, header_count_low, header_count_high;
    logic [5:0] header_check;
    logic [2:0] target_block_select;
    logic [1:0] irq_status, irq_mask, int_events;
    logic [31:0] next_rdata;
    logic a_write, line_flag, act, accept, offset_auto_step, prefetch_read_enable;
    logic wr_offset, wr_data, rd_data, step, rd_pulse;
    // Equality of a latched register index with a decode constant
    function automatic logic hcia_match(input hcia_byte_t idx, input hcia_byte_t want);
        hcia_match = (idx == want);
    endfunction : hcia_match
    // Offset plus one; an eight-bit sum rolls from the top back to zero
    function automatic hcia_byte_t hcia_step(input hcia_byte_t off);
        hcia_step = off + `HCIA_OFFSET_ONE;
    endfunction : hcia_step
    // Control fields
    assign target_block_select = indirect_control[`HCIA_SEL_HI:`HCIA_SEL_LO];
    assign offset_auto_step = indirect_control[`HCIA_AUTO_BIT];
    assign prefetch_read_enable = indirect_control[`HCIA_PREF_BIT];
    // Bus decode; every access takes one wait state so read data is registered
    assign accept = hsel && htrans[1] && hready;
    assign act = (bus_state == HCIA_BUS_WAIT);
    assign wr_offset = act && a_write && hcia_match(a_idx, `HCIA_IDX_OFFSET);
    assign wr_data = act && a_write && hcia_match(a_idx, `HCIA_IDX_DATA);
    assign rd_data = act && !a_write && hcia_match(a_idx, `HCIA_IDX_DATA);
    // Step after a completed data access in either direction
    assign step = offset_auto_step && (wr_data || rd_data);
    // Prefetch strobes on offset writes, and after data reads when stepping
    assign rd_pulse = prefetch_read_enable &&
        (wr_offset || (rd_data && offset_auto_step));
    // Offset next value: a bus write wins over a step in the same access
    assign next_offset = wr_offset ? hwdata[7:0] :
        (step ? hcia_step(indirect_offset) : indirect_offset);
    // Read data of the selected set; unknown targets read as zero
    always_comb
    begin
        case (target_block_select)
            `HCIA_SEL_PATTERN: sel_rdata = pattern_rdata;
            `HCIA_SEL_ANALOG: sel_rdata = analog_rdata;
            default: sel_rdata = `HCIA_BYTE_RST;
        endcase
    end
    // Register read mux; unmapped indices read as zero
    always_comb
    begin
        next_rdata = 32'h0000_0000;
        case (a_idx)
            `HCIA_IDX_CHAN: next_rdata[7:0] = header_channel_and_type;
            `HCIA_IDX_CNT_LO: next_rdata[7:0] = header_count_low;
            `HCIA_IDX_CNT_HI: next_rdata[7:0] = header_count_high;
            `HCIA_IDX_CHECK: next_rdata[7:0] = {line_flag, 1'b0, header_check};
            `HCIA_IDX_CTRL: next_rdata[7:0] = indirect_control;
            `HCIA_IDX_OFFSET: next_rdata[7:0] = indirect_offset;
            `HCIA_IDX_DATA: next_rdata[7:0] = sel_rdata;
            `HCIA_IDX_ID0: next_rdata[7:0] = ID_BYTE0;
            `HCIA_IDX_ID1: next_rdata[7:0] = ID_BYTE1;
            `HCIA_IDX_ID2: next_rdata[7:0] = ID_BYTE2;
            `HCIA_IDX_ID3: next_rdata[7:0] = ID_BYTE3;
            `HCIA_IDX_ID4: next_rdata[7:0] = ID_BYTE4;
            `HCIA_IDX_IRQ_STAT: next_rdata[1:0] = irq_status;
            `HCIA_IDX_IRQ_MASK: next_rdata[1:0] = irq_mask;
            default: next_rdata = 32'h0000_0000;
        endcase
    end
    // Bus phase machine and address latch
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            bus_state <= HCIA_BUS_IDLE;
            hreadyout <= 1'b1;
            a_idx <= `HCIA_BYTE_RST;
            a_write <= 1'b0;
        end
        else
        begin
            case (bus_state)
                HCIA_BUS_IDLE:
                begin
                    if (accept)
                    begin
                        bus_state <= HCIA_BUS_WAIT;
                        hreadyout <= 1'b0;
                        a_idx <= haddr[9:2];
                        a_write <= hwrite;
                    end
                end
                HCIA_BUS_WAIT:
                begin
                    bus_state <= HCIA_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
                default:
                begin
                    bus_state <= HCIA_BUS_IDLE;
                    hreadyout <= 1'b1;
                end
            endcase
        end
    end
    // Read data and response; this slave never signals an error
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            hrdata <= 32'h0000_0000;
            hresp <= 1'b0;
        end
        else if (act && !a_write)
        begin
            hrdata <= next_rdata;
        end
    end
    // Header capture: one enable loads every field, so no mix of two packets
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            header_channel_and_type <= `HCIA_BYTE_RST;
            header_count_low <= `HCIA_BYTE_RST;
            header_count_high <= `HCIA_BYTE_RST;
            header_check <= 6'h00;
        end
        else if (hdr_valid)
        begin
            header_channel_and_type <= {hdr_channel, hdr_type};
            header_count_low <= hdr_count[7:0];
            header_count_high <= hdr_count[15:8];
            header_check <= hdr_check;
        end
    end
    // Line change flag lasts for the frame; a new event beats frame start
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            line_flag <= 1'b0;
        end
        else if (line_change_event)
        begin
            line_flag <= 1'b1;
        end
        else if (frame_start)
        begin
            line_flag <= 1'b0;
        end
    end
    // Control register; reserved bits 7:5 stay zero
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            indirect_control <= `HCIA_CTRL_RST;
        end
        else if (act && a_write && hcia_match(a_idx, `HCIA_IDX_CTRL))
        begin
            indirect_control <= hwdata[7:0] & `HCIA_CTRL_MASK;
        end
    end
    // Offset register and its mirror toward the register sets
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            indirect_offset <= `HCIA_OFFSET_RST;
            ind_rd_offset <= `HCIA_OFFSET_RST;
        end
        else
        begin
            indirect_offset <= next_offset;
            ind_rd_offset <= next_offset;
        end
    end
    // Strobes; write data and offset are held so a step cannot disturb them
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pattern_wr_strobe <= 1'b0;
            analog_wr_strobe <= 1'b0;
            pattern_rd_strobe <= 1'b0;
            analog_rd_strobe <= 1'b0;
            ind_wr_offset <= `HCIA_OFFSET_RST;
            ind_wdata <= `HCIA_BYTE_RST;
        end
        else
        begin
            pattern_wr_strobe <= wr_data &&
                (target_block_select == `HCIA_SEL_PATTERN);
            analog_wr_strobe <= wr_data &&
                (target_block_select == `HCIA_SEL_ANALOG);
            pattern_rd_strobe <= rd_pulse &&
                (target_block_select == `HCIA_SEL_PATTERN);
            analog_rd_strobe <= rd_pulse &&
                (target_block_select == `HCIA_SEL_ANALOG);
            if (wr_data)
            begin
                ind_wr_offset <= indirect_offset;
                ind_wdata <= hwdata[7:0];
            end
        end
    end
    // Interrupt events: header captured and line length changed
    assign int_events = {line_change_event, hdr_valid};
    // Sticky status, write one to clear; a new event wins over the clear
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq_status <= `HCIA_INT_RST;
            irq_mask <= `HCIA_INT_RST;
        end
        else
        begin
            if (act && a_write && hcia_match(a_idx, `HCIA_IDX_IRQ_STAT))
            begin
                irq_status <= (irq_status & ~hwdata[1:0]) | int_events;
            end
            else
            begin
                irq_status <= irq_status | int_events;
            end
            if (act && a_write && hcia_match(a_idx, `HCIA_IDX_IRQ_MASK))
            begin
                irq_mask <= hwdata[1:0];
            end
        end
    end
    // Level interrupt, one cycle behind the status bits
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= |(irq_status & irq_mask);
        end
    end
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);
    // Bus handshake steps
    sequence s_accept;
        hsel && htrans[1] && hready;
    endsequence
    sequence s_wait_done;
        !hreadyout ##1 hreadyout;
    endsequence
    property p_bus_wait;
        s_accept |=> s_wait_done;
    endproperty
    a_bus_wait: assert property (p_bus_wait)
        else $error("transfer did not finish after one wait state");
    property p_hdr_fields;
        hdr_valid |=> header_channel_and_type == $past({hdr_channel, hdr_type});
    endproperty
    a_hdr_fields: assert property (p_hdr_fields)
        else $error("channel and type not captured");
    property p_hdr_count;
        hdr_valid |=> {header_count_high, header_count_low} == $past(hdr_count);
    endproperty
    a_hdr_count: assert property (p_hdr_count)
        else $error("payload count not captured");
    property p_hdr_hold;
        !hdr_valid |=> $stable(header_count_low) && $stable(header_check)
            && $stable(header_channel_and_type) && $stable(header_count_high);
    endproperty
    a_hdr_hold: assert property (p_hdr_hold)
        else $error("header fields changed without a header");
    property p_check_read;
        act && !a_write && hcia_match(a_idx, `HCIA_IDX_CHECK) |=>
            hrdata[6] == 1'b0 && hrdata[5:0] == $past(header_check) && hreadyout;
    endproperty
    a_check_read: assert property (p_check_read)
        else $error("check register read wrong");
    property p_line_flag;
        line_change_event |=> line_flag [*1] ##1 (line_flag || $past(frame_start));
    endproperty
    a_line_flag: assert property (p_line_flag)
        else $error("line change flag not set");
    property p_step;
        (wr_data || rd_data) && offset_auto_step |=>
            indirect_offset == hcia_step($past(indirect_offset));
    endproperty
    a_step: assert property (p_step)
        else $error("offset did not step");
    property p_wrap;
        (wr_data || rd_data) && offset_auto_step && indirect_offset == 8'hff |=>
            indirect_offset == 8'h00;
    endproperty
    a_wrap: assert property (p_wrap)
        else $error("offset did not wrap");
    property p_prefetch_offset;
        wr_offset && prefetch_read_enable && target_block_select == `HCIA_SEL_PATTERN
            |=> pattern_rd_strobe && ind_rd_offset == $past(hwdata[7:0]) ##1 !pattern_rd_strobe;
    endproperty
    a_prefetch_offset: assert property (p_prefetch_offset)
        else $error("no prefetch strobe on offset write");
    property p_prefetch_step;
        rd_data && prefetch_read_enable && offset_auto_step &&
            target_block_select == `HCIA_SEL_ANALOG |=> analog_rd_strobe && !pattern_rd_strobe;
    endproperty
    a_prefetch_step: assert property (p_prefetch_step)
        else $error("no prefetch strobe after stepped read");
    property p_no_prefetch;
        !prefetch_read_enable |=> !pattern_rd_strobe && !analog_rd_strobe;
    endproperty
    a_no_prefetch: assert property (p_no_prefetch)
        else $error("read strobe without prefetch");
    property p_write_data;
        wr_data && target_block_select == `HCIA_SEL_ANALOG |=> analog_wr_strobe &&
            ind_wdata == $past(hwdata[7:0]) && ind_wr_offset == $past(indirect_offset);
    endproperty
    a_write_data: assert property (p_write_data)
        else $error("indirect write lost");
    property p_read_data;
        rd_data |=> hrdata[7:0] == $past(sel_rdata) && hrdata[31:8] == 24'h000000;
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("indirect read data wrong");
    property p_ident;
        act && !a_write && hcia_match(a_idx, `HCIA_IDX_ID2) |=> hrdata == {24'h000000, ID_BYTE2};
    endproperty
    a_ident: assert property (p_ident)
        else $error("identification byte wrong");
    property p_offset_write;
        wr_offset |=> indirect_offset == $past(hwdata[7:0]);
    endproperty
    a_offset_write: assert property (p_offset_write)
        else $error("offset not written");
endmodule : hcia_top

// file: pkg/hcia_defs.svh
// Register indices, field positions and reset values of the header/indirect bank
`ifndef HCIA_DEFS_SVH
`define HCIA_DEFS_SVH
`define HCIA_IDX_CHAN 8'h61
`define HCIA_IDX_CNT_LO 8'h62
`define HCIA_IDX_CNT_HI 8'h63
`define HCIA_IDX_CHECK 8'h64
`define HCIA_IDX_CTRL 8'hb0
`define HCIA_IDX_OFFSET 8'hb1
`define HCIA_IDX_DATA 8'hb2
`define HCIA_IDX_ID0 8'hf0
`define HCIA_IDX_ID1 8'hf1
`define HCIA_IDX_ID2 8'hf2
`define HCIA_IDX_ID3 8'hf3
`define HCIA_IDX_ID4 8'hf4
`define HCIA_IDX_IRQ_STAT 8'hc0
`define HCIA_IDX_IRQ_MASK 8'hc1
`define HCIA_SEL_HI 4
`define HCIA_SEL_LO 2
`define HCIA_AUTO_BIT 1
`define HCIA_PREF_BIT 0
`define HCIA_CTRL_MASK 8'h1f
`define HCIA_CTRL_RST 8'h00
`define HCIA_OFFSET_RST 8'h00
`define HCIA_BYTE_RST 8'h00
`define HCIA_SEL_PATTERN 3'h0
`define HCIA_SEL_ANALOG 3'h1
`define HCIA_INT_HDR 0
`define HCIA_INT_LINE 1
`define HCIA_INT_RST 2'h0
`define HCIA_OFFSET_ONE 8'h01
`endif

// file: pkg/hcia_pkg.sv
// Types shared by the header capture and indirect access bank
package hcia_pkg;
    typedef enum logic [0:0] {
        HCIA_BUS_IDLE = 1'b0,
        HCIA_BUS_WAIT = 1'b1
    } hcia_bus_t;
    typedef logic [7:0] hcia_byte_t;
endpackage : hcia_pkg

// file: tb/hcia_tb_top.sv
// Self-checking bench for the header capture and indirect access bank
`timescale 1ns/1ps
`include "hcia_defs.svh"

`define CHK(what, exp, got) \
    begin \
        n_tests++; \
        if ((got) !== (exp)) \
        begin \
            miscompares++; \
            $display("unexpected %s: expected %h seen %h", what, exp, got); \
        end \
    end

module hcia_tb_top;
    import hcia_pkg::*;
    // Arbitrary identification values, only to prove the readback path
    localparam hcia_byte_t ID0 = 8'h1a;
    localparam hcia_byte_t ID1 = 8'h2b;
    localparam hcia_byte_t ID2 = 8'h3c;
    localparam hcia_byte_t ID3 = 8'h4d;
    localparam hcia_byte_t ID4 = 8'h5e;
    localparam int MAX_CYCLES = 4000;
    logic hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic [1:0] htrans, hdr_channel;
    logic [2:0] hsize;
    logic [5:0] hdr_type, hdr_check;
    logic [15:0] hdr_count;
    logic hdr_valid, line_change_event, frame_start;
    logic pattern_wr_strobe, pattern_rd_strobe, analog_wr_strobe, analog_rd_strobe;
    hcia_byte_t pattern_rdata, analog_rdata, ind_rd_offset, ind_wr_offset, ind_wdata;
    hcia_byte_t last_wr_off, last_wr_data, last_rd_off;
    hcia_byte_t ids [5] = '{ID0, ID1, ID2, ID3, ID4};
    int miscompares = 0, n_tests = 0, cycles = 0;
    int n_pwr = 0, n_prd = 0, n_awr = 0, n_ard = 0;

    hcia_top #(.ID_BYTE0(ID0), .ID_BYTE1(ID1), .ID_BYTE2(ID2), .ID_BYTE3(ID3),
        .ID_BYTE4(ID4)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq),
        .hdr_valid(hdr_valid), .hdr_channel(hdr_channel), .hdr_type(hdr_type),
        .hdr_count(hdr_count), .hdr_check(hdr_check),
        .line_change_event(line_change_event), .frame_start(frame_start),
        .pattern_rdata(pattern_rdata), .analog_rdata(analog_rdata),
        .pattern_wr_strobe(pattern_wr_strobe), .pattern_rd_strobe(pattern_rd_strobe),
        .analog_wr_strobe(analog_wr_strobe), .analog_rd_strobe(analog_rd_strobe),
        .ind_rd_offset(ind_rd_offset), .ind_wr_offset(ind_wr_offset), .ind_wdata(ind_wdata));

    // Single slave, so its ready is the bus ready
    assign hready = hreadyout;
    // Register sets answer combinationally with distinct offset patterns
    assign analog_rdata = ind_rd_offset ^ 8'h3c;
    assign pattern_rdata = ind_rd_offset + 8'h11;

    initial
    begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end

    // Strobe monitor; counting cycles also catches strobes wider than one
    always @(posedge hclk)
    begin
        cycles++;
        if (pattern_wr_strobe === 1'b1)
            n_pwr++;
        if (pattern_rd_strobe === 1'b1)
            n_prd++;
        if (analog_rd_strobe === 1'b1)
            n_ard++;
        if (pattern_rd_strobe === 1'b1 || analog_rd_strobe === 1'b1)
            last_rd_off = ind_rd_offset;
        if (analog_wr_strobe === 1'b1 || pattern_wr_strobe === 1'b1)
        begin
            n_awr += (analog_wr_strobe === 1'b1);
            last_wr_off = ind_wr_offset;
            last_wr_data = ind_wdata;
        end
        if (cycles == MAX_CYCLES)
        begin
            miscompares++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : wrap_up

    // One AHB single transfer; waits on hready, never on a fixed count
    task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
        hsel <= 1'b1;
        htrans <= 2'b10;
        haddr <= {22'h0, idx, 2'b00};
        hwrite <= wr;
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= {24'h0, wd};
        @(posedge hclk);
        while (hready !== 1'b1)
            @(posedge hclk);
        rd = hrdata;
        `CHK("response", 1'b0, hresp)
    endtask : bus

    task automatic rd_chk(input string what, input logic [7:0] idx, input logic [7:0] exp);
        bus(1'b0, idx, 8'h00);
        `CHK(what, {24'h0, exp}, rd)
    endtask : rd_chk

    // Lets registered strobes and the irq lag land before looking
    task automatic settle;
        repeat (2) @(posedge hclk);
    endtask : settle

    task automatic hdr(input logic [1:0] ch, input logic [5:0] ty, input logic [15:0] cnt,
        input logic [5:0] ck);
        hdr_channel <= ch;
        hdr_type <= ty;
        hdr_count <= cnt;
        hdr_check <= ck;
        hdr_valid <= 1'b1;
        @(posedge hclk);
        hdr_valid <= 1'b0;
        @(posedge hclk);
    endtask : hdr

    task automatic pulse(input logic line);
        line_change_event <= line;
        frame_start <= !line;
        @(posedge hclk);
        line_change_event <= 1'b0;
        frame_start <= 1'b0;
        settle();
    endtask : pulse

    task automatic test_reset_values;
        rd_chk("channel and type", `HCIA_IDX_CHAN, 8'h00);
        rd_chk("count low", `HCIA_IDX_CNT_LO, 8'h00);
        rd_chk("check byte", `HCIA_IDX_CHECK, 8'h00);
        rd_chk("control", `HCIA_IDX_CTRL, 8'h00);
        rd_chk("offset", `HCIA_IDX_OFFSET, 8'h00);
        for (int i = 0; i < 5; i++)
            rd_chk("ident byte", `HCIA_IDX_ID0 + 8'(i), ids[i]);
        bus(1'b1, `HCIA_IDX_ID0, 8'h00);
        rd_chk("ident after write", `HCIA_IDX_ID0, ID0);
        bus(1'b1, 8'h80, 8'hff);
        rd_chk("unmapped", 8'h80, 8'h00);
        $display("test reset values finished");
    endtask : test_reset_values

    task automatic test_header;
        hdr(2'h2, 6'h2b, 16'hbeef, 6'h15);
        bus(1'b1, `HCIA_IDX_CHAN, 8'hff);
        rd_chk("channel and type", `HCIA_IDX_CHAN, 8'hab);
        rd_chk("count low", `HCIA_IDX_CNT_LO, 8'hef);
        rd_chk("count high", `HCIA_IDX_CNT_HI, 8'hbe);
        rd_chk("check byte", `HCIA_IDX_CHECK, 8'h15);
        hdr(2'h3, 6'h01, 16'h1234, 6'h3f);
        rd_chk("second channel", `HCIA_IDX_CHAN, 8'hc1);
        rd_chk("second count low", `HCIA_IDX_CNT_LO, 8'h34);
        rd_chk("second count high", `HCIA_IDX_CNT_HI, 8'h12);
        rd_chk("second check", `HCIA_IDX_CHECK, 8'h3f);
        rd_chk("irq status", `HCIA_IDX_IRQ_STAT, 8'h01);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, `HCIA_IDX_IRQ_MASK, 8'h01);
        settle();
        `CHK("irq raised", 1'b1, irq)
        bus(1'b1, `HCIA_IDX_IRQ_STAT, 8'h01);
        settle();
        `CHK("irq cleared", 1'b0, irq)
        rd_chk("irq status", `HCIA_IDX_IRQ_STAT, 8'h00);
        $display("test header finished");
    endtask : test_header

    task automatic test_line_flag;
        bus(1'b1, `HCIA_IDX_IRQ_MASK, 8'h00);
        pulse(1'b1);
        rd_chk("line flag set", `HCIA_IDX_CHECK, 8'hbf);
        rd_chk("line flag kept", `HCIA_IDX_CHECK, 8'hbf);
        `CHK("irq masked", 1'b0, irq)
        bus(1'b1, `HCIA_IDX_IRQ_MASK, 8'h02);
        rd_chk("irq mask", `HCIA_IDX_IRQ_MASK, 8'h02);
        settle();
        `CHK("irq line", 1'b1, irq)
        pulse(1'b0);
        rd_chk("line flag cleared", `HCIA_IDX_CHECK, 8'h3f);
        bus(1'b1, `HCIA_IDX_IRQ_STAT, 8'h02);
        settle();
        `CHK("irq line cleared", 1'b0, irq)
        $display("test line flag finished");
    endtask : test_line_flag

    task automatic test_indirect_write;
        int a0, p0, r0;
        bus(1'b1, `HCIA_IDX_CTRL, 8'hff);
        rd_chk("control mask", `HCIA_IDX_CTRL, 8'h1f);
        bus(1'b1, `HCIA_IDX_CTRL, 8'h06);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'hfe);
        a0 = n_awr;
        p0 = n_pwr;
        r0 = n_ard;
        bus(1'b1, `HCIA_IDX_DATA, 8'ha5);
        settle();
        `CHK("analog writes", a0 + 1, n_awr)
        `CHK("pattern writes", p0, n_pwr)
        `CHK("write offset", 8'hfe, last_wr_off)
        `CHK("write data", 8'ha5, last_wr_data)
        `CHK("stepped offset", 8'hff, ind_rd_offset)
        bus(1'b1, `HCIA_IDX_DATA, 8'h5a);
        settle();
        `CHK("top offset write", 8'hff, last_wr_off)
        rd_chk("wrapped offset", `HCIA_IDX_OFFSET, 8'h00);
        `CHK("no prefetch", r0, n_ard)
        bus(1'b1, `HCIA_IDX_CTRL, 8'h00);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h07);
        bus(1'b1, `HCIA_IDX_DATA, 8'h33);
        settle();
        `CHK("pattern writes", p0 + 1, n_pwr)
        `CHK("pattern data", 8'h33, last_wr_data)
        rd_chk("offset held", `HCIA_IDX_OFFSET, 8'h07);
        $display("test indirect write finished");
    endtask : test_indirect_write

    task automatic test_indirect_read;
        bus(1'b1, `HCIA_IDX_CTRL, 8'h06);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h10);
        rd_chk("analog read", `HCIA_IDX_DATA, 8'h2c);
        rd_chk("analog next", `HCIA_IDX_DATA, 8'h2d);
        bus(1'b1, `HCIA_IDX_CTRL, 8'h02);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h40);
        rd_chk("pattern read", `HCIA_IDX_DATA, 8'h51);
        rd_chk("pattern next", `HCIA_IDX_DATA, 8'h52);
        $display("test indirect read finished");
    endtask : test_indirect_read

    task automatic test_prefetch;
        int r0, p0;
        r0 = n_ard;
        p0 = n_prd;
        bus(1'b1, `HCIA_IDX_CTRL, 8'h07);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h20);
        settle();
        `CHK("offset prefetch", r0 + 1, n_ard)
        `CHK("prefetch offset", 8'h20, last_rd_off)
        rd_chk("prefetched read", `HCIA_IDX_DATA, 8'h1c);
        settle();
        `CHK("read prefetch", r0 + 2, n_ard)
        `CHK("stepped prefetch", 8'h21, last_rd_off)
        bus(1'b1, `HCIA_IDX_CTRL, 8'h05);
        bus(1'b0, `HCIA_IDX_DATA, 8'h00);
        settle();
        `CHK("no step prefetch", r0 + 2, n_ard)
        bus(1'b1, `HCIA_IDX_CTRL, 8'h01);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h30);
        settle();
        `CHK("pattern prefetch", p0 + 1, n_prd)
        `CHK("analog quiet", r0 + 2, n_ard)
        $display("test prefetch finished");
    endtask : test_prefetch

    task automatic test_bad_select;
        int a0, p0, r0, q0;
        a0 = n_awr;
        p0 = n_pwr;
        r0 = n_ard;
        q0 = n_prd;
        bus(1'b1, `HCIA_IDX_CTRL, 8'h0b);
        bus(1'b1, `HCIA_IDX_OFFSET, 8'h50);
        bus(1'b1, `HCIA_IDX_DATA, 8'h77);
        rd_chk("unselected read", `HCIA_IDX_DATA, 8'h00);
        settle();
        `CHK("no write strobes", a0 + p0, n_awr + n_pwr)
        `CHK("no read strobes", r0 + q0, n_ard + n_prd)
        $display("test bad select finished");
    endtask : test_bad_select

    initial
    begin
        hresetn = 1'b0;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'b00;
        hwrite = 1'b0;
        hsize = 3'b010;
        hwdata = 32'h0;
        hdr_valid = 1'b0;
        hdr_channel = 2'h0;
        hdr_type = 6'h00;
        hdr_count = 16'h0000;
        hdr_check = 6'h00;
        line_change_event = 1'b0;
        frame_start = 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        test_reset_values();
        test_header();
        test_line_flag();
        test_indirect_write();
        test_indirect_read();
        test_prefetch();
        test_bad_select();
        wrap_up();
    end
endmodule : hcia_tb_top
